// ### rtl/ulms_line_modem_status.sv
// module: serial line status, modem control/status and scratch registers
`timescale 1ns/1ns
module ulms_line_modem_status (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // i/o port access
  input  wire logic [9:0] io_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  // mode and datapath status
  input  wire logic       fifo_mode_i,
  input  wire logic       thr_wr_i,
  input  wire logic       iir_rd_i,
  input  wire logic       tx_hold_empty_i,
  input  wire logic       tx_shift_empty_i,
  input  wire logic       rx_char_done_i,
  input  wire logic       rx_parity_bad_i,
  input  wire logic       rx_stop_bad_i,
  input  wire logic       rx_break_i,
  input  wire logic       rx_buf_rd_i,
  input  wire logic       rx_fifo_empty_i,
  input  wire logic       rx_fifo_full_i,
  input  wire logic       rx_top_break_i,
  input  wire logic       rx_top_framing_i,
  input  wire logic       rx_top_parity_i,
  input  wire logic       rx_fifo_err_any_i,
  input  wire logic       rx_top_valid_i,
  // modem pins, receive push qualifier and interrupt outputs
  input  wire logic       cts_i,
  input  wire logic       dsr_i,
  input  wire logic       ri_i,
  input  wire logic       dcd_i,
  output logic            dtr_o,
  output logic            rts_o,
  output logic            aux_output_one_o,
  output logic            aux_output_two_o,
  output logic            loopback_o,
  output logic            rx_fifo_push_ok_o,
  output logic            tx_empty_irq_o,
  output logic            line_irq_o,
  output logic            modem_irq_o
);
  import ulms_pkg::*;
  logic [7:0] mcr;
  logic [7:0] scratch;
  logic       rx_data_available;
  logic       overrun;
  logic       break_seen;
  logic       framing_fault;
  logic       parity_fault;
  logic       err_sticky;
  logic       tx_irq;
  logic       hold_empty_q;
  logic       in_break;
  logic [7:0] lsr;
  logic [7:0] msr;
  logic       lsr_rd;
  logic       msr_rd;
  logic       tx_holding_empty;
  logic       transmitter_fully_empty;
  logic       rx_hold_full;

  assign lsr_rd = io_rd_i && (io_addr_i == ADDR_LINE_STAT);
  assign msr_rd = io_rd_i && (io_addr_i == ADDR_MODEM_STAT);

  //------------------------------------------------------------
  // modem control and scratch
  //------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mcr <= MODEM_CTRL_RESET;
    end else if (io_wr_i && io_addr_i == ADDR_MODEM_CTRL) begin
      mcr <= {3'h0, io_wdata_i[4:0]};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scratch <= SCRATCH_RESET;
    end else if (io_wr_i && io_addr_i == ADDR_SCRATCH) begin
      scratch <= io_wdata_i;
    end
  end
  // loopback forces modem outputs inactive
  assign dtr_o            = mcr[MC_DTR] && !mcr[MC_LOOP];
  assign rts_o            = mcr[MC_RTS] && !mcr[MC_LOOP];
  assign aux_output_one_o = mcr[MC_AUX1] && !mcr[MC_LOOP];
  assign aux_output_two_o = mcr[MC_AUX2] && !mcr[MC_LOOP];
  assign loopback_o       = mcr[MC_LOOP];

  //------------------------------------------------------------
  // transmitter status
  //------------------------------------------------------------
  // in fifo mode tx_hold_empty_i reports the transmit fifo empty
  assign tx_holding_empty        = tx_hold_empty_i;
  assign transmitter_fully_empty = tx_hold_empty_i && tx_shift_empty_i;
  // previous empty level, resets to idle so no false edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_empty_q <= 1'b1;
    end else begin
      hold_empty_q <= tx_hold_empty_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_irq <= 1'b0;
    end else if (fifo_mode_i && tx_hold_empty_i && !tx_irq && !hold_empty_q) begin
      tx_irq <= 1'b1;
    end else if (thr_wr_i || iir_rd_i) begin
      tx_irq <= 1'b0;
    end
  end
  assign tx_empty_irq_o = tx_irq;

  //------------------------------------------------------------
  // receiver status
  //------------------------------------------------------------
  // one break entry per break, then wait for a valid start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_break <= 1'b0;
    end else if (rx_char_done_i && rx_break_i) begin
      in_break <= 1'b1;
    end else if (rx_char_done_i) begin
      in_break <= 1'b0;
    end
  end
  assign rx_fifo_push_ok_o = fifo_mode_i && rx_char_done_i && !rx_fifo_full_i &&
                             !(in_break && rx_break_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_hold_full <= 1'b0;
    end else if (rx_char_done_i && !fifo_mode_i) begin
      rx_hold_full <= 1'b1;
    end else if (rx_buf_rd_i) begin
      rx_hold_full <= 1'b0;
    end
  end
  assign rx_data_available = fifo_mode_i ? !rx_fifo_empty_i : rx_hold_full;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrun <= 1'b0;
    end else if (rx_char_done_i && (fifo_mode_i ? rx_fifo_full_i : rx_hold_full)) begin
      overrun <= 1'b1;
    end else if (lsr_rd) begin
      overrun <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      break_seen    <= 1'b0;
      framing_fault <= 1'b0;
      parity_fault  <= 1'b0;
    end else begin
      // set wins over the read clear
      if (fifo_mode_i ? (rx_top_valid_i && rx_top_break_i)
                      : (rx_char_done_i && rx_break_i && !in_break)) begin
        break_seen <= 1'b1;
      end else if (lsr_rd) begin
        break_seen <= 1'b0;
      end
      if (fifo_mode_i ? (rx_top_valid_i && rx_top_framing_i)
                      : (rx_char_done_i && rx_stop_bad_i)) begin
        framing_fault <= 1'b1;
      end else if (lsr_rd) begin
        framing_fault <= 1'b0;
      end
      if (fifo_mode_i ? (rx_top_valid_i && rx_top_parity_i)
                      : (rx_char_done_i && rx_parity_bad_i)) begin
        parity_fault <= 1'b1;
      end else if (lsr_rd) begin
        parity_fault <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_sticky <= 1'b0;
    end else if (!fifo_mode_i) begin
      err_sticky <= 1'b0;
    end else if (rx_fifo_err_any_i) begin
      err_sticky <= 1'b1;
    end else if (lsr_rd) begin
      err_sticky <= 1'b0;
    end
  end

  always_comb begin
    lsr          = 8'h00;
    lsr[LS_ERR]  = fifo_mode_i && err_sticky;
    lsr[LS_TX_DONE] = transmitter_fully_empty;
    lsr[LS_THE]  = tx_holding_empty;
    lsr[LS_BRK]  = break_seen;
    lsr[LS_FRM]  = framing_fault;
    lsr[LS_PAR]  = parity_fault;
    lsr[LS_OVR]  = overrun;
    lsr[LS_DAV]  = rx_data_available;
  end
  // cause bits stay readable whatever the interrupt enable
  assign line_irq_o = overrun || parity_fault || framing_fault || break_seen;

  //------------------------------------------------------------
  // modem status
  //------------------------------------------------------------
  ulms_modem_status u_modem (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .cts_i     (cts_i),
    .dsr_i     (dsr_i),
    .ri_i      (ri_i),
    .dcd_i     (dcd_i),
    .mcr_i     (mcr),
    .msr_rd_i  (msr_rd),
    .msr_o     (msr),
    .msr_irq_o (modem_irq_o)
  );

  //------------------------------------------------------------
  // read data
  //------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      unique case (io_addr_i)
        ADDR_MODEM_CTRL: io_rdata_o <= mcr;
        ADDR_LINE_STAT:  io_rdata_o <= lsr;
        ADDR_MODEM_STAT: io_rdata_o <= msr;
        ADDR_SCRATCH:    io_rdata_o <= scratch;
        default:         io_rdata_o <= 8'h00;
      endcase
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  dtr_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    io_wr_i && io_addr_i == ADDR_MODEM_CTRL && !io_wdata_i[4]
    |=> dtr_o == $past(io_wdata_i[0])) else $error("terminal ready wrong");
  err_bit_nonfifo_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !fifo_mode_i |-> !lsr[LS_ERR]) else $error("error bit set outside fifo mode");
  tx_done_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lsr[LS_TX_DONE] == (tx_hold_empty_i && tx_shift_empty_i)) else $error("empty bit wrong");
  tx_irq_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_irq && (thr_wr_i || iir_rd_i) && $past(tx_hold_empty_i) |=> !tx_irq)
    else $error("tx irq not cleared");
  overrun_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_char_done_i && !fifo_mode_i && rx_hold_full |=> overrun)
    else $error("overrun missed");
  fifo_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_fifo_full_i |-> !rx_fifo_push_ok_o) else $error("push into full fifo");
  lsr_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lsr_rd && !rx_char_done_i && !rx_top_valid_i |=> !parity_fault && !framing_fault)
    else $error("latched flags not cleared");
  scratch_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    io_wr_i && io_addr_i == ADDR_SCRATCH |=> scratch == $past(io_wdata_i))
    else $error("scratch not stored");
endmodule // ulms_line_modem_status

// ### inc/ulms_pkg.sv
// package: constants and register map for the serial line and modem status block
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
package ulms_pkg;
  localparam logic [9:0] ADDR_MODEM_CTRL = 10'h3fc;
  localparam logic [9:0] ADDR_LINE_STAT  = 10'h3fd;
  localparam logic [9:0] ADDR_MODEM_STAT = 10'h3fe;
  localparam logic [9:0] ADDR_SCRATCH    = 10'h3ff;
  localparam logic [7:0] LINE_STAT_RESET = 8'h60;
  localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET   = 8'h00;
  localparam int LS_ERR  = 7;
  localparam int LS_TX_DONE = 6;
  localparam int LS_THE  = 5;
  localparam int LS_BRK  = 4;
  localparam int LS_FRM  = 3;
  localparam int LS_PAR  = 2;
  localparam int LS_OVR  = 1;
  localparam int LS_DAV  = 0;
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_AUX1 = 2;
  localparam int MC_AUX2 = 3;
  localparam int MC_LOOP = 4;
endpackage : ulms_pkg

// ### rtl/ulms_modem_status.sv
// module: modem status live bits and change flags
`timescale 1ns/1ns
module ulms_modem_status (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cts_i,
  input  wire logic       dsr_i,
  input  wire logic       ri_i,
  input  wire logic       dcd_i,
  input  wire logic [7:0] mcr_i,
  input  wire logic       msr_rd_i,
  output logic      [7:0] msr_o,
  output logic            msr_irq_o
);
  import ulms_pkg::*;
  logic [3:0] live;
  logic [3:0] prev;
  logic [3:0] delta;
  logic       primed;
  // live order: dcd, ri, dsr, cts
  always_comb begin
    if (mcr_i[MC_LOOP]) begin
      live = {mcr_i[MC_AUX2], mcr_i[MC_AUX1], mcr_i[MC_DTR], mcr_i[MC_RTS]};
    end else begin
      live = {dcd_i, ri_i, dsr_i, cts_i};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev   <= 4'h0;
      primed <= 1'b0;
    end else begin
      prev   <= live;
      primed <= 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      delta <= 4'h0;
    end else begin
      // set wins over read clear
      delta[3] <= (primed && (live[3] != prev[3])) || (delta[3] && !msr_rd_i);
      delta[2] <= (primed && prev[2] && !live[2]) || (delta[2] && !msr_rd_i);
      delta[1] <= (primed && (live[1] != prev[1])) || (delta[1] && !msr_rd_i);
      delta[0] <= (primed && (live[0] != prev[0])) || (delta[0] && !msr_rd_i);
    end
  end
  assign msr_o     = {live, delta};
  assign msr_irq_o = |delta;

  ring_trail_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    primed && $fell(live[2]) |=> delta[2]) else $error("ring edge not latched");
  delta_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    msr_rd_i && (live == prev) |=> !msr_irq_o) else $error("modem read did not clear");
endmodule // ulms_modem_status

// ### sim/ulms_modem_peer.sv
// partner model: remote modem driving the status lines after a lag
`timescale 1ns/1ns
module ulms_modem_peer #(
  parameter int LAG = 2
) (
  input  wire logic       clk_i,
  input  wire logic [3:0] want_i,
  output logic            cts_o,
  output logic            dsr_o,
  output logic            ri_o,
  output logic            dcd_o
);
  logic [3:0] pipe [LAG] = '{default: '0};
  // lines change off the sampling edge
  always @(negedge clk_i) begin
    pipe[0] <= want_i;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign {dcd_o, ri_o, dsr_o, cts_o} = pipe[LAG-1];
endmodule // ulms_modem_peer

// ### sim/tb_uart_line_modem_status.sv
// testbench: register access and status flag scenarios
`timescale 1ns/1ns
module tb_uart_line_modem_status;
  import ulms_pkg::*;
  logic       clk_i = 0;
  logic       rst_n_i = 0;
  logic [9:0] io_addr_i = '0;
  logic       io_rd_i = 0;
  logic       io_wr_i = 0;
  logic [7:0] io_wdata_i = '0;
  logic [7:0] io_rdata_o;
  logic       fifo_mode_i = 0;
  logic [4:0] pul = '0;
  logic [2:0] qual = '0;
  logic [2:0] top = '0;
  logic [3:0] want = '0;
  logic       hold_e = 1, shift_e = 1, f_empty = 1, f_full = 0, err_any = 0;
  logic       cts, dsr, ri, dcd, dtr, rts, loop_o, push_ok, txe_irq, line_irq;
  logic       aux1, aux2, mdm_irq;
  logic [7:0] rdv;
  int         n_errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  // ----------------------------------------
  // clock, timeout, instances
  // ----------------------------------------
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  ulms_modem_peer peer (.clk_i(clk_i), .want_i(want), .cts_o(cts), .dsr_o(dsr),
    .ri_o(ri), .dcd_o(dcd));
  ulms_line_modem_status dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i),
    .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .fifo_mode_i(fifo_mode_i), .thr_wr_i(pul[0]), .iir_rd_i(pul[1]),
    .tx_hold_empty_i(hold_e), .tx_shift_empty_i(shift_e), .rx_char_done_i(pul[2]),
    .rx_parity_bad_i(qual[0]), .rx_stop_bad_i(qual[1]), .rx_break_i(qual[2]),
    .rx_buf_rd_i(pul[3]), .rx_fifo_empty_i(f_empty), .rx_fifo_full_i(f_full),
    .rx_top_break_i(top[2]), .rx_top_framing_i(top[1]), .rx_top_parity_i(top[0]),
    .rx_fifo_err_any_i(err_any), .rx_top_valid_i(pul[4]), .cts_i(cts), .dsr_i(dsr),
    .ri_i(ri), .dcd_i(dcd), .dtr_o(dtr), .rts_o(rts), .aux_output_one_o(aux1),
    .aux_output_two_o(aux2), .loopback_o(loop_o), .rx_fifo_push_ok_o(push_ok),
    .tx_empty_irq_o(txe_irq), .line_irq_o(line_irq), .modem_irq_o(mdm_irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic io_read(input logic [9:0] a);
    @(negedge clk_i);
    io_addr_i = a;
    io_rd_i = 1;
    @(negedge clk_i);
    io_rd_i = 0;
    rdv = io_rdata_o;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    io_read(a);
    chk8($sformatf("port %h", a), e, rdv);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1;
    @(negedge clk_i);
    io_wr_i = 0;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(negedge clk_i);
    pul = m;
    @(negedge clk_i);
    pul = '0;
  endtask
  task automatic push_chk(input logic e);
    @(negedge clk_i);
    pul = 5'h04;
    #1;
    chk1("push ok", e, push_ok);
    @(negedge clk_i);
    pul = '0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1;
    rd(ADDR_LINE_STAT, LINE_STAT_RESET);
    rd(ADDR_MODEM_STAT, 8'h00);
    wr(ADDR_LINE_STAT, 8'h00);
    rd(ADDR_LINE_STAT, 8'h60);
    rd(10'h3f0, 8'h00);
    wr(ADDR_SCRATCH, 8'ha5);
    rd(ADDR_SCRATCH, 8'ha5);
    wr(ADDR_MODEM_CTRL, 8'he1);
    rd(ADDR_MODEM_CTRL, 8'h01);
    chk1("dtr", 1'b1, dtr);
    wr(ADDR_MODEM_CTRL, 8'h0e);
    chk1("dtr", 1'b0, dtr);
    chk1("rts", 1'b1, rts);
    chk1("aux one", 1'b1, aux1);
    chk1("aux two", 1'b1, aux2);
    for (int i = 0; i < 4; i++) begin
      want[i] = 1'b1;
      repeat (4) @(negedge clk_i);
      chk1("modem irq", 1'(i != 2), mdm_irq);
      rd(ADDR_MODEM_STAT, {want, (i == 2) ? 4'h0 : 4'(1 << i)});
      rd(ADDR_MODEM_STAT, {want, 4'h0});
      chk1("modem irq", 1'b0, mdm_irq);
    end
    want = '0;
    repeat (4) @(negedge clk_i);
    chk1("modem irq", 1'b1, mdm_irq);
    rd(ADDR_MODEM_STAT, 8'h0f);
    wr(ADDR_MODEM_CTRL, 8'h1f);
    chk1("dtr", 1'b0, dtr);
    chk1("rts", 1'b0, rts);
    chk1("loop", 1'b1, loop_o);
    chk1("aux one", 1'b0, aux1);
    chk1("aux two", 1'b0, aux2);
    io_read(ADDR_MODEM_STAT);
    rd(ADDR_MODEM_STAT, 8'hf0);
    wr(ADDR_MODEM_CTRL, 8'h11);
    rd(ADDR_MODEM_STAT, 8'h2d);
    wr(ADDR_MODEM_CTRL, 8'h00);
    io_read(ADDR_MODEM_STAT);
    for (int k = 0; k < 3; k++) begin
      qual = 3'(1 << k);
      pulse(5'h04);
      qual = '0;
      chk1("line irq", 1'b1, line_irq);
      rd(ADDR_LINE_STAT, 8'h61 | (8'h04 << k));
      rd(ADDR_LINE_STAT, 8'h61);
      pulse(5'h08);
      rd(ADDR_LINE_STAT, 8'h60);
    end
    pulse(5'h04);
    pulse(5'h04);
    rd(ADDR_LINE_STAT, 8'h63);
    pulse(5'h08);
    rd(ADDR_LINE_STAT, 8'h60);
    hold_e = 0;
    pulse(5'h01);
    rd(ADDR_LINE_STAT, 8'h00);
    hold_e = 1;
    shift_e = 0;
    rd(ADDR_LINE_STAT, 8'h20);
    shift_e = 1;
    fifo_mode_i = 1;
    hold_e = 0;
    @(negedge clk_i);
    hold_e = 1;
    repeat (2) @(negedge clk_i);
    chk1("tx empty irq", 1'b1, txe_irq);
    hold_e = 0;
    pulse(5'h01);
    chk1("tx empty irq", 1'b0, txe_irq);
    hold_e = 1;
    repeat (2) @(negedge clk_i);
    chk1("tx empty irq", 1'b1, txe_irq);
    pulse(5'h02);
    chk1("tx empty irq", 1'b0, txe_irq);
    rd(ADDR_LINE_STAT, 8'h60);
    f_empty = 0;
    err_any = 1;
    for (int k = 0; k < 3; k++) begin
      top = 3'(1 << k);
      pulse(5'h10);
      top = '0;
      rd(ADDR_LINE_STAT, 8'he1 | (8'h04 << k));
      rd(ADDR_LINE_STAT, 8'he1);
    end
    err_any = 0;
    io_read(ADDR_LINE_STAT);
    rd(ADDR_LINE_STAT, 8'h61);
    f_full = 1;
    push_chk(1'b0);
    rd(ADDR_LINE_STAT, 8'h63);
    f_full = 0;
    push_chk(1'b1);
    rd(ADDR_LINE_STAT, 8'h61);
    f_empty = 1;
    pulse(5'h08);
    rd(ADDR_LINE_STAT, 8'h60);
    final_report();
  end
endmodule // tb_uart_line_modem_status
